// ==== rtl/flbsel_top.sv ====
// Framer loopback selector with its line transmit buffer.
//
// Notes on behaviour
// - Primary register: address bits 0-4, code 5-7
// - Code 001 loops line; 000 disables all primary loops
// - Code 010 loops system, sends AIS line
// - Code 011 loops addressed slot on system
// - Code 100 loops addressed slot to line
// - Code 101 copies addressed slot into slot0
// - Code 110, alt 0: regenerated payload line loop
// - Regenerated E1 loop rebuilds whole slot 0
// - Receive path keeps delivering normal system data
// - Code 110, alt 1: nailed connect into slot0
// - Code 111 passes line, inserts system data-link
// - ESF passthrough CRC-6 excludes data-link bits
// - E1 passthrough CRC-4 includes data-link bits
// - Secondary register: address 0-4, code 5-6
// - Secondary 01 single-slot system loop; 00 off
// - Secondary 10 single-slot line loop; 11 reserved
// - Secondary needs distinct address, compatible primary
// - Idle code register defaults to 7F
`timescale 1ns/100ps
`default_nettype none
`include "flbsel_consts.svh"

// Synchronous FIFO with a registered head word
module flbsel_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] ROOM = CW'(DEPTH - 2);

  // Whole buffer state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage words
    logic [AW-1:0] wr; // Write pointer
    logic [AW-1:0] rd; // Read pointer
    logic [CW-1:0] cnt; // Words held in storage
    logic ready; // Two or more places free
    logic ovalid; // Head register full
    logic [WIDTH-1:0] odata; // Head register word
  } flbsel_fifo_s;

  flbsel_fifo_s fifo_q;
  flbsel_fifo_s fifo_d;
  logic push;
  logic pop;
  logic load;

  // Next state of the buffer
  always_comb begin
    fifo_d = fifo_q;
    load = ~fifo_q.ovalid | out_ready;
    // Ready keeps one slot of slack for a push already in flight
    push = ce & in_valid & (fifo_q.cnt != CW'(DEPTH));
    pop = ce & load & (fifo_q.cnt != '0);
    if (push) begin
      fifo_d.mem[fifo_q.wr] = in_data;
      fifo_d.wr = fifo_q.wr + AW'(1);
    end
    if (pop) begin
      fifo_d.odata = fifo_q.mem[fifo_q.rd];
      fifo_d.rd = fifo_q.rd + AW'(1);
    end
    if (ce & load) begin
      fifo_d.ovalid = pop;
    end
    fifo_d.cnt = fifo_q.cnt + CW'(push) - CW'(pop);
    fifo_d.ready = fifo_d.cnt <= ROOM;
  end

  // Buffer register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_q <= '0;
      fifo_q.ready <= 1'b1;
    end else begin
      fifo_q <= fifo_d;
    end
  end

  assign in_ready = fifo_q.ready;
  assign out_valid = fifo_q.ovalid;
  assign out_data = fifo_q.odata;
endmodule : flbsel_fifo

// Loopback selection for one framer channel
module flbsel_top
  import flbsel_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Framing context from the framer
  input wire logic e1_mode,
  // Time-slot stream in, both directions aligned
  input wire logic slot_valid,
  output logic slot_ready,
  input wire logic [4:0] slot_idx,
  input wire logic [7:0] line_rx_byte,
  input wire logic [7:0] sys_rx_byte,
  input wire logic [7:0] dl_mask,
  input wire logic [7:0] sys_dl_bits,
  // System highway transmit
  output logic sys_tx_valid,
  output logic [7:0] sys_tx_byte,
  // Line transmit, buffered
  output logic line_tx_valid,
  input wire logic line_tx_ready,
  output logic [7:0] line_tx_byte,
  // Controls to the framer engines
  output logic regen_framing,
  output logic regen_ts0,
  output logic crc6_skip_dl,
  output logic crc4_keep_dl,
  output logic [7:0] line_idle_code
);
  // Whole block state
  typedef struct packed {
    flbsel_byte_t pri; // primary_loopback_ctrl
    logic [6:0] sec; // secondary_loopback_ctrl, bit 7 reads 0
    flbsel_byte_t idle; // line_idle_code_reg
    flbsel_byte_t alt; // alt_mode_select_reg
    flbsel_byte_t rdata; // Read answer, one cycle
    flbsel_byte_t held; // Addressed slot kept for slot 0
    flbsel_byte_t stx; // System transmit byte
    logic svalid; // System transmit strobe
    flbsel_byte_t ltx; // Line byte going into the buffer
    logic push; // Line byte strobe
    logic regen; // Regenerated framing request
    logic regen0; // Whole slot 0 rebuild request
    logic crc6x; // CRC-6 skips data-link bits
    logic crc4i; // CRC-4 counts data-link bits
    logic sec_on; // Secondary loop in force
  } flbsel_top_s;

  flbsel_top_s st_q;
  flbsel_top_s st_d;
  flbsel_pcode_e pcode;
  flbsel_scode_e scode;
  flbsel_slot_t paddr;
  flbsel_slot_t saddr;
  logic take;
  logic buf_ready;
  logic alt_bit;

  // Slot match, used for both addresses
  function automatic logic slot_hit(input flbsel_slot_t s,
                                    input flbsel_slot_t a);
    slot_hit = (s == a);
  endfunction : slot_hit

  // Primary codes that leave room for the secondary loop
  function automatic logic sec_allowed(input flbsel_pcode_e p);
    sec_allowed = !(p == FLBSEL_P_LINE || p == FLBSEL_P_BOARD ||
                    p == FLBSEL_P_PAYLOAD || p == FLBSEL_P_PASS);
  endfunction : sec_allowed

  // Field decode of the control registers
  assign pcode = flbsel_pcode_e'(
                   st_q.pri[`FLBSEL_PCODE_MSB:`FLBSEL_PCODE_LSB]);
  assign paddr = st_q.pri[`FLBSEL_ADDR_MSB:`FLBSEL_ADDR_LSB];
  assign scode = flbsel_scode_e'(
                   st_q.sec[`FLBSEL_SCODE_MSB:`FLBSEL_SCODE_LSB]);
  assign saddr = st_q.sec[`FLBSEL_ADDR_MSB:`FLBSEL_ADDR_LSB];
  assign alt_bit = st_q.alt[`FLBSEL_ALT_BIT];
  // Slot taken only while the buffer can hold its line byte
  assign take = ce & slot_valid & buf_ready;

  // Next state: registers, loop selection, engine controls
  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.rdata = '0;
      st_d.push = 1'b0;
      st_d.svalid = 1'b0;
      // Register writes
      if (reg_wr) begin
        case (reg_addr)
          `FLBSEL_OFF_PRI: st_d.pri = reg_wdata;
          `FLBSEL_OFF_SEC: st_d.sec = reg_wdata[6:0];
          `FLBSEL_OFF_IDLE: st_d.idle = reg_wdata;
          `FLBSEL_OFF_ALT: st_d.alt = reg_wdata;
          default: ; // Unmapped writes dropped
        endcase
      end
      // Register reads, answered next cycle
      if (reg_rd) begin
        case (reg_addr)
          `FLBSEL_OFF_PRI: st_d.rdata = st_q.pri;
          `FLBSEL_OFF_SEC: st_d.rdata = {1'b0, st_q.sec};
          `FLBSEL_OFF_IDLE: st_d.rdata = st_q.idle;
          `FLBSEL_OFF_ALT: st_d.rdata = st_q.alt;
          `FLBSEL_OFF_STAT: st_d.rdata = {3'h0, st_q.sec_on, st_q.crc4i,
                                          st_q.crc6x, st_q.regen0,
                                          st_q.regen};
          default: st_d.rdata = '0; // Unmapped reads zero
        endcase
      end
      // Engine controls follow the live codes
      st_d.regen = (pcode == FLBSEL_P_PAYLOAD) & ~alt_bit;
      st_d.regen0 = (pcode == FLBSEL_P_PAYLOAD) & ~alt_bit & e1_mode;
      st_d.crc6x = (pcode == FLBSEL_P_PASS) & ~e1_mode;
      st_d.crc4i = (pcode == FLBSEL_P_PASS) & e1_mode;
      // Code 11 falls out here, same as 00
      st_d.sec_on = sec_allowed(pcode) & ~slot_hit(saddr, paddr) &
                    (scode == FLBSEL_S_SYS || scode == FLBSEL_S_LINE);
      // One time slot through the selector
      if (take) begin
        st_d.push = 1'b1;
        st_d.svalid = 1'b1;
        // Normal paths: system to line, line to system
        st_d.ltx = sys_rx_byte;
        st_d.stx = line_rx_byte;
        case (pcode)
          FLBSEL_P_NONE: ; // Straight through
          FLBSEL_P_LINE: st_d.ltx = line_rx_byte;
          FLBSEL_P_BOARD: begin
            st_d.stx = sys_rx_byte;
            st_d.ltx = `FLBSEL_AIS_BYTE;
          end
          FLBSEL_P_SYS_SLOT: begin
            if (slot_hit(slot_idx, paddr)) begin
              st_d.stx = sys_rx_byte;
              st_d.ltx = st_q.idle;
            end
          end
          FLBSEL_P_LINE_SLOT: begin
            if (slot_hit(slot_idx, paddr)) begin
              st_d.ltx = line_rx_byte;
              st_d.stx = st_q.idle;
            end
          end
          FLBSEL_P_BCAST: begin
            // Slot 0 carries the copy kept from the previous frame
            if (slot_hit(slot_idx, `FLBSEL_SLOT0)) begin
              st_d.ltx = st_q.held;
            end
            if (slot_hit(slot_idx, paddr)) begin
              st_d.held = sys_rx_byte;
            end
          end
          FLBSEL_P_PAYLOAD: begin
            if (!alt_bit) begin
              // Overhead bits are rebuilt by the transmit framer
              st_d.ltx = line_rx_byte;
            end else begin
              if (slot_hit(slot_idx, `FLBSEL_SLOT0)) begin
                st_d.stx = st_q.held;
              end
              if (slot_hit(slot_idx, paddr)) begin
                st_d.held = sys_rx_byte;
              end
            end
          end
          FLBSEL_P_PASS: begin
            st_d.ltx = (line_rx_byte & ~dl_mask) |
                       (sys_dl_bits & dl_mask);
          end
          default: ;
        endcase
        // Secondary single-slot loop on top
        // Live gate too, so a fresh primary write bars it at once
        if (st_q.sec_on && sec_allowed(pcode) && !slot_hit(saddr, paddr) &&
            slot_hit(slot_idx, saddr)) begin
          case (scode)
            FLBSEL_S_SYS: begin
              st_d.stx = sys_rx_byte;
              st_d.ltx = st_q.idle;
            end
            FLBSEL_S_LINE: begin
              st_d.ltx = line_rx_byte;
              st_d.stx = st_q.idle;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Block register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.pri <= `FLBSEL_PRI_RST;
      st_q.sec <= `FLBSEL_SEC_RST;
      st_q.idle <= `FLBSEL_IDLE_RST;
      st_q.alt <= `FLBSEL_ALT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Line transmit buffer; its ready stalls the slot stream
  flbsel_fifo #(
    .WIDTH(`FLBSEL_FIFO_WIDTH),
    .DEPTH(`FLBSEL_FIFO_DEPTH)
  ) u_line_buf (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_valid(st_q.push),
    .in_ready(buf_ready),
    .in_data(st_q.ltx),
    .out_valid(line_tx_valid),
    .out_ready(line_tx_ready),
    .out_data(line_tx_byte)
  );

  // Registered outputs
  assign slot_ready = buf_ready;
  assign reg_rdata = st_q.rdata;
  assign sys_tx_valid = st_q.svalid;
  assign sys_tx_byte = st_q.stx;
  assign regen_framing = st_q.regen;
  assign regen_ts0 = st_q.regen0;
  assign crc6_skip_dl = st_q.crc6x;
  assign crc4_keep_dl = st_q.crc4i;
  assign line_idle_code = st_q.idle;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_line_loop_path: assert property (
    take && pcode == FLBSEL_P_LINE && !st_q.sec_on
    |=> st_q.ltx == $past(line_rx_byte))
    else $error("line loop byte wrong");
  a_board_ais_out: assert property (
    take && pcode == FLBSEL_P_BOARD
    |=> st_q.ltx == `FLBSEL_AIS_BYTE && sys_tx_byte == $past(sys_rx_byte))
    else $error("board loop paths wrong");
  a_sys_slot_idle: assert property (
    take && pcode == FLBSEL_P_SYS_SLOT && slot_idx == paddr
    |=> st_q.ltx == $past(st_q.idle) && sys_tx_valid)
    else $error("system slot loop wrong");
  a_line_slot_idle: assert property (
    take && pcode == FLBSEL_P_LINE_SLOT && slot_idx == paddr
    |=> sys_tx_byte == $past(st_q.idle))
    else $error("line slot loop wrong");
  a_regen_flag: assert property (
    ce && pcode == FLBSEL_P_PAYLOAD && !alt_bit
    |=> regen_framing)
    else $error("regen flag missing");
  a_pass_dl_insert: assert property (
    take && pcode == FLBSEL_P_PASS
    |=> st_q.ltx == (($past(line_rx_byte) & ~$past(dl_mask)) |
                     ($past(sys_dl_bits) & $past(dl_mask))))
    else $error("data-link insert wrong");
  a_crc_flags: assert property (
    !(crc6_skip_dl && crc4_keep_dl))
    else $error("crc flags both set");
  a_sec_gate: assert property (
    st_q.sec_on |-> sec_allowed($past(pcode)) || !$past(ce))
    else $error("secondary on when barred");
  a_read_one_cycle: assert property (
    ce && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data stands too long");
  a_push_stalls: assert property (
    ce && slot_valid && !slot_ready |=> !sys_tx_valid)
    else $error("slot taken while stalled");
endmodule : flbsel_top
`default_nettype wire

// ==== rtl/flbsel_consts.svh ====
// Constants of the framer loopback selector: offsets, fields, resets.
`ifndef FLBSEL_CONSTS_SVH
`define FLBSEL_CONSTS_SVH
// Register offsets on the plain register port
`define FLBSEL_OFF_PRI 3'h0
`define FLBSEL_OFF_SEC 3'h1
`define FLBSEL_OFF_IDLE 3'h2
`define FLBSEL_OFF_ALT 3'h3
`define FLBSEL_OFF_STAT 3'h4
// Field positions
`define FLBSEL_ADDR_LSB 0
`define FLBSEL_ADDR_MSB 4
`define FLBSEL_PCODE_LSB 5
`define FLBSEL_PCODE_MSB 7
`define FLBSEL_SCODE_LSB 5
`define FLBSEL_SCODE_MSB 6
`define FLBSEL_ALT_BIT 3
// Reset values
`define FLBSEL_PRI_RST 8'h00
`define FLBSEL_SEC_RST 7'h00
`define FLBSEL_IDLE_RST 8'h7F
`define FLBSEL_ALT_RST 8'h00
// Fixed byte patterns and slots
`define FLBSEL_AIS_BYTE 8'hFF
`define FLBSEL_SLOT0 5'h00
// Line transmit buffer shape
`define FLBSEL_FIFO_DEPTH 16
`define FLBSEL_FIFO_WIDTH 8
`endif

// ==== rtl/flbsel_pkg.sv ====
// Types shared by the framer loopback selector.
package flbsel_pkg;
  // Primary loopback control codes
  typedef enum logic [2:0] {
    FLBSEL_P_NONE = 3'h0,
    FLBSEL_P_LINE = 3'h1,
    FLBSEL_P_BOARD = 3'h2,
    FLBSEL_P_SYS_SLOT = 3'h3,
    FLBSEL_P_LINE_SLOT = 3'h4,
    FLBSEL_P_BCAST = 3'h5,
    FLBSEL_P_PAYLOAD = 3'h6,
    FLBSEL_P_PASS = 3'h7
  } flbsel_pcode_e;
  // Secondary loopback control codes
  typedef enum logic [1:0] {
    FLBSEL_S_NONE = 2'h0,
    FLBSEL_S_SYS = 2'h1,
    FLBSEL_S_LINE = 2'h2,
    FLBSEL_S_RSVD = 2'h3
  } flbsel_scode_e;
  typedef logic [4:0] flbsel_slot_t;
  typedef logic [7:0] flbsel_byte_t;
endpackage : flbsel_pkg

// ==== tb/flbsel_partner.sv ====
// Line-side drain model: takes looped bytes with stall and slow pacing.
`timescale 1ns/100ps
`default_nettype none
module flbsel_partner
  import flbsel_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pace controls from the bench
  input wire logic stall,
  input wire logic slow,
  // Line transmit drain
  input wire logic valid,
  input wire logic [7:0] data,
  output logic ready
);
  flbsel_byte_t got[$]; // Bytes taken, oldest first
  // Take on valid and ready; slow mode drops ready every other cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b0;
    end else begin
      if (valid && ready) begin
        got.push_back(data);
      end
      ready <= !stall && !(slow && ready);
    end
  end
endmodule : flbsel_partner
`default_nettype wire

// ==== tb/tb_flbsel_top.sv ====
// Self-checking bench for the framer loopback selector.
`timescale 1ns/100ps
`default_nettype none
module tb_flbsel_top;
  import flbsel_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1; // Clock enable on, dropped only around one write in t_regs
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, line_idle_code;
  logic reg_wr = 1'b0, reg_rd = 1'b0, e1_mode = 1'b1;
  logic slot_valid = 1'b0, slot_ready, sys_tx_valid, line_tx_valid;
  logic [4:0] slot_idx = 5'h00;
  logic [7:0] line_rx_byte = 8'h00, sys_rx_byte = 8'h00, sys_tx_byte;
  logic [7:0] dl_mask = 8'h00, sys_dl_bits = 8'h0A, line_tx_byte;
  logic line_tx_ready, stall = 1'b0, slow = 1'b0;
  logic regen_framing, regen_ts0, crc6_skip_dl, crc4_keep_dl;
  int fails = 0, n_checks = 0;
  localparam logic [7:0] L = 8'hC3, S = 8'h3C, I = 8'h5A; // Test bytes
  // 25 MHz clock
  always #20 clk = ~clk;
  flbsel_top flbsel_top_i (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .e1_mode, .slot_valid, .slot_ready, .slot_idx,
    .line_rx_byte, .sys_rx_byte, .dl_mask, .sys_dl_bits, .sys_tx_valid,
    .sys_tx_byte, .line_tx_valid, .line_tx_ready, .line_tx_byte,
    .regen_framing, .regen_ts0, .crc6_skip_dl, .crc4_keep_dl,
    .line_idle_code);
  flbsel_partner flbsel_partner_i (.clk, .rst, .stall, .slow,
    .valid(line_tx_valid), .data(line_tx_byte), .ready(line_tx_ready));
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  // One-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read strobe, data judged in the following cycle only
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask : rd
  // Framer control flags packed low to high
  function automatic logic [7:0] flags();
    return {4'h0, crc4_keep_dl, crc6_skip_dl, regen_ts0, regen_framing};
  endfunction : flags
  // Offer one slot; judge highway byte next cycle and line byte on drain
  task automatic send(input logic [4:0] i, input logic [7:0] l, s, es, el);
    int k;
    @(posedge clk);
    slot_idx <= i;
    line_rx_byte <= l;
    sys_rx_byte <= s;
    slot_valid <= 1'b1;
    @(negedge clk);
    for (k = 0; k < 50 && slot_ready !== 1'b1; k++) @(negedge clk);
    @(posedge clk);
    slot_valid <= 1'b0;
    @(negedge clk);
    chk({7'h0, sys_tx_valid}, 8'h01);
    chk(sys_tx_byte, es);
    for (k = 0; k < 50 && flbsel_partner_i.got.size() == 0; k++) begin
      @(negedge clk);
    end
    chk(flbsel_partner_i.got.size() > 0 ?
        flbsel_partner_i.got.pop_front() : 8'hXX, el);
  endtask : send
  // Reset values, reserved bit, unmapped place, idle code
  task automatic t_regs;
    rd(0, 8'h00);
    rd(1, 8'h00);
    rd(2, 8'h7F);
    chk(line_idle_code, 8'h7F);
    rd(3, 8'h00);
    wr(1, 8'hFF);
    rd(1, 8'h7F);
    wr(7, 8'hAA);
    rd(7, 8'h00);
    wr(1, 8'h00);
    wr(2, I);
    rd(2, I);
    chk(line_idle_code, I);
    @(posedge clk);
    ce <= 1'b0;
    wr(0, 8'hFF);
    ce <= 1'b1;
    rd(0, 8'h00);
    $display("done: registers");
  endtask : t_regs
  // Every primary code on the addressed slot 3
  task automatic t_prim;
    logic [7:0] es[8] = '{L, L, S, S, I, L, L, L};
    logic [7:0] el[8] = '{S, L, 8'hFF, I, L, S, L, 8'hCA};
    int c;
    for (c = 0; c < 8; c++) begin
      dl_mask <= (c == 7) ? 8'h0F : 8'h00;
      wr(0, {c[2:0], 5'h03});
      send(3, L, S, es[c], el[c]);
      if (c == 3 || c == 4) send(4, L, S, L, S);
    end
    dl_mask <= 8'h00;
    $display("done: primary codes");
  endtask : t_prim
  // Regeneration and checksum flags in both framings
  task automatic t_flags;
    int e;
    for (e = 0; e < 2; e++) begin
      e1_mode <= e[0];
      wr(0, 8'hC0);
      repeat (2) @(negedge clk);
      chk(flags(), e ? 8'h03 : 8'h01);
      wr(0, 8'hE0);
      rd(4, e ? 8'h08 : 8'h04);
      chk(flags(), e ? 8'h08 : 8'h04);
    end
    $display("done: flags");
  endtask : t_flags
  // Broadcast and nailed connect into slot 0
  task automatic t_slot0;
    wr(0, 8'hA3);
    send(3, L, 8'h66, L, 8'h66);
    send(0, 8'h22, 8'h11, 8'h22, 8'h66);
    wr(3, 8'h08);
    wr(0, 8'hC3);
    rd(4, 8'h00);
    send(3, 8'h55, 8'h44, 8'h55, 8'h44);
    send(0, 8'h22, 8'h11, 8'h44, 8'h11);
    wr(3, 8'h00);
    $display("done: slot zero");
  endtask : t_slot0
  // Secondary loopback codes and the conditions that disable it
  task automatic t_sec;
    wr(0, 8'h63);
    wr(1, 8'h45);
    rd(4, 8'h10);
    send(5, L, S, I, L);
    wr(1, 8'h25);
    send(5, L, S, S, I);
    wr(1, 8'h65);
    rd(4, 8'h00);
    send(5, L, S, L, S);
    wr(1, 8'h23);
    rd(4, 8'h00);
    wr(1, 8'h25);
    wr(0, 8'h23);
    rd(4, 8'h00);
    send(5, L, S, L, L);
    wr(1, 8'h00);
    wr(0, 8'h00);
    $display("done: secondary");
  endtask : t_sec
  // Fill the line buffer with the drain stalled, then drain slowly
  task automatic t_fill;
    int n, k;
    n = 0;
    @(posedge clk);
    stall <= 1'b1;
    slot_idx <= 5'h07;
    sys_rx_byte <= 8'h80;
    slot_valid <= 1'b1;
    for (k = 0; k < 30; k++) begin
      @(negedge clk);
      if (slot_ready !== 1'b1) break;
      @(posedge clk);
      n++;
      sys_rx_byte <= 8'h80 + 8'(n);
    end
    @(posedge clk);
    slot_valid <= 1'b0;
    chk({7'h0, n > 10 && n < 18}, 8'h01);
    stall <= 1'b0;
    slow <= 1'b1;
    for (k = 0; k < 200 && flbsel_partner_i.got.size() < n; k++) begin
      @(posedge clk);
    end
    chk(8'(flbsel_partner_i.got.size()), 8'(n));
    for (k = 0; k < n; k++) begin
      chk(flbsel_partner_i.got.pop_front(), 8'h80 + 8'(k));
    end
    slow <= 1'b0;
    $display("done: buffer");
  endtask : t_fill
  // Main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_prim();
    t_flags();
    t_slot0();
    t_sec();
    t_fill();
    stop_test();
  end
  // Watchdog: far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    fails++;
    stop_test();
  end
endmodule : tb_flbsel_top
`default_nettype wire
